// file: inc/sie_pkg.sv
// Constants, types and helper functions for the serial input expander.
// Assumes a two-wire bus slave on a sampling link clock and a core clock.
//
// How it works
// - low strap pulls 3..0, high strap 7..4
// - bus-line strap follows that line's level
// - address is 110 then four strap bits
// - each strap decodes two address bits
// - bus-line straps read high before first transfer
// - changed inputs set sticky change flags
// - address acknowledge resamples inputs, clears flags
// - flags stay set until next access
// - flags set regardless of interrupt mask
// - eight-bit mask written over the bus
// - one-byte read returns inputs, clears flags
// - second byte returns flags before the clear
// - interrupt released at address acknowledge
// - long reads alternate and resample per pair
// - no interrupt during read; deferred until stop
// - no stop interrupt for already sent changes
// - start, address plus direction, data, stop
// - start and stop are data edges, clock high
// - receiver drives ninth bit low as acknowledge
// - clock input only, data open drain
// - strap address re-evaluated on every transmission
// - each written byte overwrites the mask
// - abort pin ends transfer, keeps mask, interrupt
// - power-up mask all ones, flags clear
package sie_pkg;

  // ----------------------------------------------------------------
  // Address and strap connection codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_PREFIX = 3'h6;
  localparam logic [1:0] CON_GND     = 2'h0;
  localparam logic [1:0] CON_VDD     = 2'h1;
  localparam logic [1:0] CON_SCL     = 2'h2;
  localparam logic [1:0] CON_SDA     = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RESET  = 8'hFF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [3:0] BITS_BYTE   = 4'h8;
  localparam logic [4:0] LINK_SYNC_RESET = 5'h1F;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR   = 7'h08,
    ST_WACK = 7'h10,
    ST_RD   = 7'h20,
    ST_RACK = 7'h40
  } sie_state_type;

  // Words handed from the core to the link for transmission
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] flags;
  } sie_tx_type;

  // ----------------------------------------------------------------
  // Strap decoding
  // ----------------------------------------------------------------
  // A strap that never differed from a bus line is tied to it
  function automatic logic [1:0] sie_classify(input logic ne_scl,
                                              input logic ne_sda,
                                              input logic lvl);
    if (!ne_scl)
      return CON_SCL;
    else if (!ne_sda)
      return CON_SDA;
    else if (lvl)
      return CON_VDD;
    else
      return CON_GND;
  endfunction

  // Upper strap order differs from the lower one
  function automatic logic [1:0] sie_hi_bits(input logic [1:0] con);
    case (con)
      CON_SCL: return 2'h0;
      CON_SDA: return 2'h1;
      CON_GND: return 2'h2;
      default: return 2'h3;
    endcase
  endfunction

endpackage

// file: hdl/sie_expander.sv
// Eight-input expander with change flags and a latching interrupt.
// Assumes a free link_clk that oversamples the bus lines, and that the
// bus clock's low phase lasts well beyond a few cycles of either clock.
module sie_expander
  import sie_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             link_clk,
  input  wire logic [WIDTH-1:0] port_inputs,
  input  wire logic             strap_sel_low,
  input  wire logic             strap_sel_high,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  input  wire logic             bus_abort_n,
  output logic                  sda_out,
  output logic                  sda_oe_n,
  output logic                  int_out,
  output logic                  int_oe_n,
  output logic [1:0]            pullup_en
);

  // ----------------------------------------------------------------
  // Link domain declarations
  // ----------------------------------------------------------------
  logic [4:0]    lk_m_ff;
  logic [4:0]    lk_s_ff;
  logic          scl_q_ff;
  logic          sda_q_ff;
  sie_state_type state_ff;
  logic [3:0]    cnt_ff;
  logic [7:0]    sh_ff;
  logic          rw_ff;
  logic          odd_ff;
  logic          claimed_ff;
  logic [1:0]    ne_scl_ff;
  logic [1:0]    ne_sda_ff;
  logic [7:0]    mask_word_ff;
  logic          smp_tgl_ff;
  logic          stp_tgl_ff;
  logic          msk_tgl_ff;
  logic          sda_oe_n_ff;
  logic [1:0]    pullup_en_ff;
  logic          scl_s;
  logic          sda_s;
  logic [1:0]    strap_s;
  logic          abort_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;
  logic [6:0]    own_addr;
  logic [7:0]    next_byte;

  // ----------------------------------------------------------------
  // Core domain declarations
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] in_m_ff;
  logic [WIDTH-1:0] in_s_ff;
  logic [WIDTH-1:0] snap_ff;
  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] mask_ff;
  logic             reading_ff;
  logic             int_n_ff;
  sie_tx_type       tx_ff;
  logic [2:0]       smp_sync_ff;
  logic [2:0]       stp_sync_ff;
  logic [2:0]       msk_sync_ff;
  logic             smp_ev;
  logic             stp_ev;
  logic             msk_ev;
  logic [WIDTH-1:0] nxt_snap;
  logic [WIDTH-1:0] nxt_flags;

  // ----------------------------------------------------------------
  // Link side: pin synchronisers
  // ----------------------------------------------------------------
  // Bus lines, straps and abort all pass two flops first
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lk_m_ff <= LINK_SYNC_RESET;
      lk_s_ff <= LINK_SYNC_RESET;
    end
    else
    begin
      lk_m_ff <= {bus_abort_n, strap_sel_high, strap_sel_low, sda_in, scl_in};
      lk_s_ff <= lk_m_ff;
    end
  end

  assign scl_s   = lk_s_ff[0];
  assign sda_s   = lk_s_ff[1];
  assign strap_s = lk_s_ff[3:2];
  assign abort_s = ~lk_s_ff[4];

  // Previous line levels for edge and condition detection
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_q_ff <= 1'h1;
      sda_q_ff <= 1'h1;
    end
    else
    begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q_ff;
  assign scl_fall  = ~scl_s & scl_q_ff;
  assign bus_start = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign bus_stop  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  // ----------------------------------------------------------------
  // Link side: strap observation and pullups
  // ----------------------------------------------------------------
  // Record whether each strap left the clock or data line level since the last start
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ne_scl_ff <= 2'h0;
      ne_sda_ff <= 2'h0;
    end
    else if (bus_start)
    begin
      ne_scl_ff <= 2'h0;
      ne_sda_ff <= 2'h0;
    end
    else
    begin
      ne_scl_ff <= ne_scl_ff | (strap_s ^ {2{scl_s}});
      ne_sda_ff <= ne_sda_ff | (strap_s ^ {2{sda_s}});
    end
  end

  // Address is rebuilt from the straps of the running transmission
  assign own_addr = {ADDR_PREFIX,
                     sie_hi_bits(sie_classify(ne_scl_ff[1], ne_sda_ff[1], strap_s[1])),
                     sie_classify(ne_scl_ff[0], ne_sda_ff[0], strap_s[0])};

  // A bus-line strap simply tracks its line, so its level is the enable;
  // before any traffic the idle-high lines therefore enable pullups
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
      pullup_en_ff <= 2'h3;
    else
      pullup_en_ff <= strap_s;
  end

  // Next transmit byte alternates data and flags
  assign next_byte = odd_ff ? tx_ff.flags : tx_ff.data;

  // ----------------------------------------------------------------
  // Link side: bus slave state machine
  // ----------------------------------------------------------------
  // tx_ff is read here only after the core had half a bus period to settle
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 4'h0;
      sh_ff        <= 8'h00;
      rw_ff        <= 1'h0;
      odd_ff       <= 1'h0;
      claimed_ff   <= 1'h0;
      mask_word_ff <= MASK_RESET;
      smp_tgl_ff   <= 1'h0;
      stp_tgl_ff   <= 1'h0;
      msk_tgl_ff   <= 1'h0;
      sda_oe_n_ff  <= 1'h1;
    end
    else if (abort_s || bus_stop)
    begin
      if (claimed_ff)
        stp_tgl_ff <= ~stp_tgl_ff;
      claimed_ff  <= 1'h0;
      state_ff    <= ST_IDLE;
      sda_oe_n_ff <= 1'h1;
    end
    else if (bus_start)
    begin
      if (claimed_ff)
        stp_tgl_ff <= ~stp_tgl_ff;
      claimed_ff  <= 1'h0;
      state_ff    <= ST_ADDR;
      cnt_ff      <= 4'h0;
      sda_oe_n_ff <= 1'h1;
    end
    else
    begin
      case (state_ff)
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            sh_ff  <= {sh_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == BITS_BYTE)
          begin
            if (sh_ff[7:1] == own_addr)
            begin
              rw_ff       <= sh_ff[0];
              claimed_ff  <= 1'h1;
              sda_oe_n_ff <= 1'h0;
              smp_tgl_ff  <= ~smp_tgl_ff;
              state_ff    <= ST_AACK;
            end
            else
              state_ff <= ST_IDLE;
          end
        end
        ST_AACK:
        begin
          if (scl_fall && rw_ff)
          begin
            sh_ff       <= tx_ff.data;
            odd_ff      <= 1'h1;
            sda_oe_n_ff <= tx_ff.data[7];
            cnt_ff      <= 4'h1;
            state_ff    <= ST_RD;
          end
          else if (scl_fall)
          begin
            sda_oe_n_ff <= 1'h1;
            cnt_ff      <= 4'h0;
            state_ff    <= ST_WR;
          end
        end
        ST_WR:
        begin
          if (scl_rise)
          begin
            sh_ff  <= {sh_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == BITS_BYTE)
          begin
            mask_word_ff <= sh_ff;
            msk_tgl_ff   <= ~msk_tgl_ff;
            sda_oe_n_ff  <= 1'h0;
            state_ff     <= ST_WACK;
          end
        end
        ST_WACK:
        begin
          if (scl_fall)
          begin
            sda_oe_n_ff <= 1'h1;
            cnt_ff      <= 4'h0;
            state_ff    <= ST_WR;
          end
        end
        ST_RD:
        begin
          if (scl_fall && cnt_ff == BITS_BYTE)
          begin
            sda_oe_n_ff <= 1'h1;
            state_ff    <= ST_RACK;
          end
          else if (scl_fall)
          begin
            sh_ff       <= {sh_ff[6:0], 1'h0};
            sda_oe_n_ff <= sh_ff[6];
            cnt_ff      <= cnt_ff + 4'h1;
          end
        end
        ST_RACK:
        begin
          if (scl_rise && sda_s)
            state_ff <= ST_IDLE; // Master declined: wait for stop
          else if (scl_rise && !odd_ff)
            smp_tgl_ff <= ~smp_tgl_ff;
          else if (scl_fall)
          begin
            sh_ff       <= next_byte;
            odd_ff      <= ~odd_ff;
            sda_oe_n_ff <= next_byte[7];
            cnt_ff      <= 4'h1;
            state_ff    <= ST_RD;
          end
        end
        default:
        begin
          sda_oe_n_ff <= 1'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core side: synchronisers and event recovery
  // ----------------------------------------------------------------
  // Inputs pass two flops; toggles get a third flop for the edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_m_ff     <= '0;
      in_s_ff     <= '0;
      smp_sync_ff <= 3'h0;
      stp_sync_ff <= 3'h0;
      msk_sync_ff <= 3'h0;
    end
    else
    begin
      in_m_ff     <= port_inputs;
      in_s_ff     <= in_m_ff;
      smp_sync_ff <= {smp_sync_ff[1:0], smp_tgl_ff};
      stp_sync_ff <= {stp_sync_ff[1:0], stp_tgl_ff};
      msk_sync_ff <= {msk_sync_ff[1:0], msk_tgl_ff};
    end
  end

  assign smp_ev = smp_sync_ff[2] ^ smp_sync_ff[1];
  assign stp_ev = stp_sync_ff[2] ^ stp_sync_ff[1];
  assign msk_ev = msk_sync_ff[2] ^ msk_sync_ff[1];

  // ----------------------------------------------------------------
  // Core side: snapshot and change flags
  // ----------------------------------------------------------------
  // A change on the clearing cycle goes into the snapshot and sets no flag
  assign nxt_snap  = smp_ev ? in_s_ff : snap_ff;
  assign nxt_flags = (smp_ev ? FLAGS_RESET : flags_ff) | (in_s_ff ^ nxt_snap);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      snap_ff  <= '0;
      flags_ff <= FLAGS_RESET;
      tx_ff    <= '0;
    end
    else
    begin
      snap_ff  <= nxt_snap;
      flags_ff <= nxt_flags;
      if (smp_ev)
      begin
        tx_ff.data  <= in_s_ff;
        tx_ff.flags <= flags_ff;
      end
    end
  end

  // Mask survives the abort pin, only power-up resets it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mask_ff <= MASK_RESET;
    else if (msk_ev)
      mask_ff <= mask_word_ff;
  end

  // ----------------------------------------------------------------
  // Core side: interrupt
  // ----------------------------------------------------------------
  // Read window holds the interrupt off; sent changes were cleared
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reading_ff <= 1'h0;
    else if (smp_ev)
      reading_ff <= rw_ff;
    else if (stp_ev)
      reading_ff <= 1'h0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      int_n_ff <= 1'h1;
    else
      int_n_ff <= ~(|(flags_ff & mask_ff) & ~reading_ff);
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      int_out <= 1'h0;
    else
      int_out <= 1'h0; // Open drain: only ever pulls low
  end

  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
      sda_out <= 1'h0;
    else
      sda_out <= 1'h0;
  end

  assign int_oe_n  = int_n_ff;
  assign sda_oe_n  = sda_oe_n_ff;
  assign pullup_en = pullup_en_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking core_cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  mask_load_a: assert property (msk_ev |=> mask_ff == $past(mask_word_ff))
    else $error("mask not loaded from written byte");
  snap_take_a: assert property (smp_ev |=> snap_ff == $past(in_s_ff))
    else $error("snapshot not taken at acknowledge");
  old_flags_a: assert property (smp_ev |=> tx_ff.flags == $past(flags_ff))
    else $error("second byte lost the old flags");
  flag_sticky_a: assert property (!smp_ev |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("change flag dropped without access");
  flag_set_a: assert property (!smp_ev && (in_s_ff != snap_ff)
                               |=> (flags_ff & $past(in_s_ff ^ snap_ff)) == $past(in_s_ff ^ snap_ff))
    else $error("differing input did not set flag");
  read_quiet_a: assert property (reading_ff |=> int_oe_n)
    else $error("interrupt asserted during read");
  irq_assert_a: assert property (!reading_ff && |(flags_ff & mask_ff) |=> !int_oe_n)
    else $error("enabled flag did not assert interrupt");
  irq_release_a: assert property (smp_ev |=> ##1 int_oe_n)
    else $error("interrupt not released after acknowledge");
  stop_end_a: assert property (stp_ev |=> !reading_ff)
    else $error("read window not closed at stop");
  ack_drive_a: assert property (@(posedge link_clk) disable iff (!resetn)
                                (state_ff == ST_AACK || state_ff == ST_WACK) |-> !sda_oe_n_ff)
    else $error("acknowledge not driven low");
  idle_free_a: assert property (@(posedge link_clk) disable iff (!resetn)
                                state_ff == ST_IDLE |=> $past(abort_s) || sda_oe_n_ff)
    else $error("data line held while idle");

  read_seen_c: cover property (smp_ev && rw_ff);
  write_seen_c: cover property (msk_ev);
  irq_seen_c: cover property ($fell(int_oe_n));
  deferred_c: cover property (reading_ff && |(flags_ff & mask_ff) ##1 stp_ev);

endmodule

// file: tb/sie_master.sv
// Two-wire bus master model that drives the expander's link side.
// Assumes the bench resolves the open-drain data line with a pull-up.
module sie_master
#(
  parameter int HALF_NS = 320
)
(
  output logic     scl,
  output logic     sda_pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines idle high, so the master releases them at time zero
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Start: data falls while the clock is high (also serves as repeated start)
  task automatic start();
    sda_pull = 1'b0;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_pull = 1'b1;
    #(HALF_NS);
    scl = 1'b0;
    #(HALF_NS);
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sda_pull = 1'b1;
    #(HALF_NS);
    scl = 1'b1;
    #(HALF_NS);
    sda_pull = 1'b0;
    #(HALF_NS);
  endtask

  // One clock pulse per bit; data changes only well inside the low phase
  // so the device never mistakes a data edge for a start or stop
  task automatic bit_io(input logic b, output logic r);
    #(HALF_NS / 4);
    sda_pull = ~b;
    #(HALF_NS * 3 / 4);
    scl = 1'b1;
    #(HALF_NS / 2);
    r = sda;
    #(HALF_NS / 2);
    scl = 1'b0;
  endtask

  // Byte out, most significant bit first, then the receiver's ninth bit
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; the master acknowledges all but the last byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// file: tb/sie_expander_tb.sv
// Self-checking bench for the serial input expander.
// Assumes the bus master model in sie_master and a free-running link clock.
module sie_expander_tb
  import sie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       link_clk;
  logic       resetn;
  logic [7:0] port_inputs;
  logic       lo_on_scl;
  logic       hi_strap;
  logic       bus_abort_n;
  logic       m_scl;
  logic       m_pull;
  logic       sda_out;
  logic       sda_oe_n;
  logic       int_out;
  logic       int_oe_n;
  logic [1:0] pullup_en;
  logic       ack;
  wire        sda_line;
  wire        int_pin;
  wire        strap_lo;
  int         n_fail;
  int         num_checks;

  localparam logic [6:0] A_GND = {ADDR_PREFIX, 4'hC};
  localparam logic [6:0] A_SCL = {ADDR_PREFIX, 4'hE};

  // Open-drain lines with pull-ups; the low strap can follow the clock line
  assign sda_line = ~(m_pull | (~sda_oe_n & ~sda_out));
  assign int_pin  = int_oe_n ? 1'b1 : int_out;
  assign strap_lo = lo_on_scl ? m_scl : 1'b0;

  sie_expander sie_expander_inst (
    .clk            (clk),
    .resetn         (resetn),
    .link_clk       (link_clk),
    .port_inputs    (port_inputs),
    .strap_sel_low  (strap_lo),
    .strap_sel_high (hi_strap),
    .scl_in         (m_scl),
    .sda_in         (sda_line),
    .bus_abort_n    (bus_abort_n),
    .sda_out        (sda_out),
    .sda_oe_n       (sda_oe_n),
    .int_out        (int_out),
    .int_oe_n       (int_oe_n),
    .pullup_en      (pullup_en)
  );

  sie_master sie_master_inst (
    .scl      (m_scl),
    .sda_pull (m_pull),
    .sda      (sda_line)
  );

  // Core and link clocks, phases unrelated
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  // --------------------------------------------------------------
  // Compare and access helpers
  // --------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  // Input change, then long enough for sync, flag and interrupt to settle
  task automatic set_in(input logic [7:0] v);
    @(posedge clk);
    #1;
    port_inputs = v;
    repeat (20) @(posedge clk);
    #1;
  endtask

  task automatic acc(input logic [6:0] a, input logic rw, input logic exp);
    sie_master_inst.start();
    sie_master_inst.send_byte({a, rw}, ack);
    chk_bit(ack, exp);
  endtask

  task automatic rd_chk(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    sie_master_inst.recv_byte(last, d);
    chk_byte(d, exp);
  endtask

  task automatic wr_chk(input logic [7:0] d, input logic exp);
    sie_master_inst.send_byte(d, ack);
    chk_bit(ack, exp);
  endtask

  task automatic fin();
    sie_master_inst.stop();
    #400;
  endtask

  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, well beyond the expected run of about 175 us
  initial
  begin
    #350000;
    n_fail++;
    results();
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial
  begin
    port_inputs = 8'h00;
    lo_on_scl = 1'b0;
    hi_strap = 1'b1;
    bus_abort_n = 1'b1;
    resetn = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    repeat (2) @(posedge link_clk);
    #1;
    resetn = 1'b1;
    repeat (6) @(posedge link_clk);
    #1;
    chk_bit(int_pin, 1'b1);
    chk_byte({6'h00, pullup_en}, 8'h02);
    set_in(8'h5A);
    chk_bit(int_pin, 1'b0);
    set_in(8'h00);
    chk_bit(int_pin, 1'b0);
    // Two-byte read: levels, then flags from before the clear
    acc(A_GND, 1'b1, 1'b1);
    chk_bit(int_pin, 1'b1);
    rd_chk(1'b0, 8'h00);
    rd_chk(1'b1, 8'h5A);
    fin();
    chk_bit(int_pin, 1'b1);
    // Every written byte overwrites the mask; the last one wins
    acc(A_GND, 1'b0, 1'b1);
    wr_chk(8'hF0, 1'b1);
    wr_chk(8'h01, 1'b1);
    fin();
    chk_bit(int_pin, 1'b1);
    set_in(8'h10);
    chk_bit(int_pin, 1'b1);
    acc(A_GND, 1'b1, 1'b1);
    rd_chk(1'b0, 8'h10);
    rd_chk(1'b1, 8'h10);
    fin();
    set_in(8'h11);
    chk_bit(int_pin, 1'b0);
    // Enabled change during a read waits for the stop
    acc(A_GND, 1'b1, 1'b1);
    set_in(8'h10);
    chk_bit(int_pin, 1'b1);
    rd_chk(1'b1, 8'h11);
    fin();
    chk_bit(int_pin, 1'b0);
    // Long read resamples per pair; a change already sent raises nothing
    acc(A_GND, 1'b1, 1'b1);
    set_in(8'h11);
    rd_chk(1'b0, 8'h10);
    rd_chk(1'b0, 8'h01);
    rd_chk(1'b0, 8'h11);
    rd_chk(1'b1, 8'h01);
    fin();
    chk_bit(int_pin, 1'b1);
    // Foreign address is refused
    acc({ADDR_PREFIX, 4'hD}, 1'b1, 1'b0);
    fin();
    // Low strap on the clock line: address and pullups follow it
    @(posedge clk);
    #1;
    lo_on_scl = 1'b1;
    #400;
    chk_byte({6'h00, pullup_en}, 8'h03);
    acc(A_SCL, 1'b0, 1'b1);
    #200;
    chk_byte({6'h00, pullup_en}, 8'h02);
    wr_chk(8'h01, 1'b1);
    fin();
    // Upper strap grounded: its pullup group off, upper address bits 10
    @(posedge clk);
    #1;
    hi_strap = 1'b0;
    #400;
    chk_byte({6'h00, pullup_en}, 8'h01);
    acc({ADDR_PREFIX, 4'hA}, 1'b1, 1'b1);
    rd_chk(1'b1, 8'h11);
    fin();
    @(posedge clk);
    #1;
    lo_on_scl = 1'b0;
    hi_strap = 1'b1;
    // Abort mid-write keeps interrupt and mask, drops the transfer
    acc(A_GND, 1'b0, 1'b1);
    set_in(8'h10);
    chk_bit(int_pin, 1'b0);
    @(posedge clk);
    #1;
    bus_abort_n = 1'b0;
    repeat (5) @(posedge link_clk);
    #1;
    bus_abort_n = 1'b1;
    #200;
    chk_bit(int_pin, 1'b0);
    wr_chk(8'hFF, 1'b0);
    fin();
    acc(A_GND, 1'b1, 1'b1);
    rd_chk(1'b1, 8'h10);
    fin();
    set_in(8'h30);
    chk_bit(int_pin, 1'b1);
    results();
  end
endmodule
